// [common/cfb_pkg.sv]
package cfb_pkg;

  // ==========================================================
  // Sizes
  localparam int NUM_PAIRS  = 6;
  localparam int NUM_BYTES  = 8;
  localparam int FIFO_DEPTH = 8;

  // ==========================================================
  // Timing
  localparam int  CLK_MHZ          = 125;
  localparam int  DRIVE_US         = 300;
  localparam int  STAB_MS          = 6;
  localparam int  DRIVE_CYCLES     = DRIVE_US * CLK_MHZ;
  localparam int  STAB_CYCLES      = STAB_MS * 1000 * CLK_MHZ;
  localparam int  SMB_MAX_KHZ      = 400;
  localparam logic [7:0] REF_TIMEOUT = 8'h40;

  // ==========================================================
  // Bus address choices
  localparam logic [6:0] ADDR_LOW  = 7'h6b;
  localparam logic [6:0] ADDR_MID  = 7'h6c;
  localparam logic [6:0] ADDR_HIGH = 7'h6d;
  localparam logic [1:0] SEL_LOW   = 2'h0;
  localparam logic [1:0] SEL_MID   = 2'h1;
  localparam logic [1:0] SEL_HIGH  = 2'h2;

  // ==========================================================
  // Register map, byte addresses and status bit positions
  localparam logic [5:0] OFS_CFG_LAST = 6'h1c;
  localparam logic [5:0] OFS_STATUS   = 6'h20;
  localparam int STAT_AWAKE   = 0;
  localparam int STAT_VALID   = 1;
  localparam int STAT_REF_RUN = 2;
  localparam int STAT_ADDR_LO = 8;

  // ==========================================================
  // Reset values of the configuration bytes
  localparam logic [7:0] RST_BYTE0 = 8'hff;
  localparam logic [7:0] RST_OTHER = 8'h00;

  // ==========================================================
  // Types
  typedef struct packed {
    logic [7:0] index;
    logic [7:0] data;
  } cfb_wr_t;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_ADDR   = 4'h1,
    ST_INDEX  = 4'h2,
    ST_COUNT  = 4'h3,
    ST_DATA   = 4'h4,
    ST_ACK    = 4'h5,
    ST_IGNORE = 4'h6
  } cfb_bus_state_t;

endpackage : cfb_pkg

// [hw/cfb_top.sv]
// Decided for this implementation: the Avalon-MM register port and the address map.
`timescale 1ns/1ps

// ==========================================================
// Write buffer between bus target and register bytes
module cfb_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             clock_i,
  input  wire logic             rst_n_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  wire              full  = (wr_ptr[AW] != rd_ptr[AW]) &&
                            (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  wire              empty = (wr_ptr == rd_ptr);
  wire              push  = in_valid_i && !full;
  wire              pop   = out_ready_i && !empty;
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = mem[rd_ptr[AW-1:0]];
  always_ff @(posedge clock_i)
  begin
    if (push)
      mem[wr_ptr[AW-1:0]] <= in_data_i;
  end
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      wr_ptr <= wr_ptr + (AW+1)'(push);
      rd_ptr <= rd_ptr + (AW+1)'(pop);
    end
  end
endmodule : cfb_fifo

// ==========================================================
// Fanout buffer control: bus target, output gating, power
module cfb_top #(
  parameter int DRIVE_CNT = cfb_pkg::DRIVE_CYCLES,
  parameter int STAB_CNT  = cfb_pkg::STAB_CYCLES
) (
  input  wire logic                           clock_i,
  input  wire logic                           rst_n_i,
  // Avalon-MM slave
  input  wire logic [5:0]                     avs_address_i,
  input  wire logic                           avs_read_i,
  input  wire logic                           avs_write_i,
  input  wire logic [31:0]                    avs_writedata_i,
  output logic      [31:0]                    avs_readdata_o,
  output logic                                avs_waitrequest_o,
  // Management bus pins
  input  wire logic                           scl_i,
  input  wire logic                           sda_i,
  output logic                                sda_o,
  output logic                                sda_oe_o,
  // Device pins
  input  wire logic                           ref_clock_i,
  input  wire logic                           powergood_sleep_n_i,
  input  wire logic [1:0]                     bus_addr_select_i,
  input  wire logic [cfb_pkg::NUM_PAIRS-1:0]  pair_enable_n_i,
  output logic      [cfb_pkg::NUM_PAIRS-1:0]  diff_clock_output_t_o,
  output logic      [cfb_pkg::NUM_PAIRS-1:0]  diff_clock_output_c_o
);
  import cfb_pkg::*;
  // ========================================================
  // Pin synchronisers; the strap is read once but still synced
  logic [1:0] scl_q, sda_q, ref_q, pg_q;
  logic [1:0] oe_q [NUM_PAIRS];
  logic [3:0] sel_q;
  logic       scl_d, sda_d, ref_d;
  always_ff @(posedge clock_i)
  begin
    sel_q <= {sel_q[1:0], bus_addr_select_i};
    scl_q <= {scl_q[0], scl_i};
    sda_q <= {sda_q[0], sda_i};
    ref_q <= {ref_q[0], ref_clock_i};
    pg_q  <= {pg_q[0], powergood_sleep_n_i};
    scl_d <= scl_q[1];
    sda_d <= sda_q[1];
    ref_d <= ref_q[1];
    for (int i = 0; i < NUM_PAIRS; i++)
      oe_q[i] <= {oe_q[i][0], pair_enable_n_i[i]};
  end
  wire scl_rise = scl_q[1] && !scl_d;
  wire scl_fall = !scl_q[1] && scl_d;
  wire start_c  = scl_q[1] && scl_d && sda_d && !sda_q[1];
  wire stop_c   = scl_q[1] && scl_d && !sda_d && sda_q[1];
  wire ref_rise = ref_q[1] && !ref_d;
  // ========================================================
  // Reference clock activity
  logic [7:0] ref_idle;
  wire        ref_running = (ref_idle < REF_TIMEOUT);
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      ref_idle <= REF_TIMEOUT;
    else if (ref_rise)
      ref_idle <= 8'h00;
    else if (ref_running)
      ref_idle <= ref_idle + 8'h01;
  end

  // ========================================================
  // Power sequencing
  logic        started, awake, valid;
  logic [1:0]  addr_sel;
  logic [31:0] wake_cnt;
  wire         pg_high = pg_q[1];
  function automatic logic [6:0] sel_addr(input logic [1:0] s);
    case (s)
      SEL_LOW:  sel_addr = ADDR_LOW;
      SEL_MID:  sel_addr = ADDR_MID;
      SEL_HIGH: sel_addr = ADDR_HIGH;
      default:  sel_addr = ADDR_MID;
    endcase
  endfunction : sel_addr
  wire [6:0] my_addr = sel_addr(addr_sel);
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      started  <= 1'b0;
      addr_sel <= SEL_MID;
      wake_cnt <= '0;
      awake    <= 1'b0;
      valid    <= 1'b0;
    end
    else if (!pg_high)
    begin
      wake_cnt <= '0;
      awake    <= 1'b0;
      valid    <= 1'b0;
    end
    else
    begin
      if (!started)
      begin
        started  <= 1'b1;
        addr_sel <= sel_q[3:2];
      end
      if (wake_cnt < 32'(STAB_CNT))
        wake_cnt <= wake_cnt + 32'h1;
      // Shorter of the two limits drives and validates together
      if (wake_cnt >= 32'(DRIVE_CNT - 1) ||
          wake_cnt >= 32'(STAB_CNT - 1))
      begin
        awake <= 1'b1;
        valid <= 1'b1;
      end
    end
  end

  // ========================================================
  // Configuration bytes
  logic [7:0] cfg [NUM_BYTES];

  function automatic int oe_bit(input int pair);
    oe_bit = (pair == 0) ? 0 : (pair < 4) ? pair + 1 : pair + 2;
  endfunction : oe_bit

  // ========================================================
  // Output gating, changed on reference rising edges, cleared every cycle while not valid
  logic [NUM_PAIRS-1:0] gate;
  logic                 ref_out;

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      gate    <= '0;
      ref_out <= 1'b0;
    end
    else
    begin
      ref_out <= ref_q[1];
      for (int i = 0; i < NUM_PAIRS; i++)
        if (ref_rise || !valid)
          gate[i] <= valid && !oe_q[i][1] &&
                     cfg[0][oe_bit(i)];
    end
  end

  assign diff_clock_output_t_o = gate & {NUM_PAIRS{ref_out}};
  assign diff_clock_output_c_o = gate & {NUM_PAIRS{!ref_out}};

  // ========================================================
  // Bus target
  cfb_bus_state_t state, ret_state;
  logic [3:0]     bit_cnt;
  logic [7:0]     shift, index;
  logic           ack_drv;
  logic           push;
  cfb_wr_t        push_word, pop_word;
  logic           fifo_ready, pop_valid, pop_ready;

  wire bus_on = ref_running && started;
  wire addr_hit = (shift[7:1] == my_addr) && !shift[0];

  assign sda_o    = 1'b0;
  assign sda_oe_o = ack_drv;

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i || !bus_on)
    begin
      state     <= ST_IDLE;
      ret_state <= ST_IDLE;
      bit_cnt   <= 4'h0;
      shift     <= 8'h00;
      index     <= 8'h00;
      ack_drv   <= 1'b0;
      push      <= 1'b0;
      push_word <= '0;
    end
    else
    begin
      push <= 1'b0;
      if (start_c)
      begin
        state   <= ST_ADDR;
        bit_cnt <= 4'h0;
        ack_drv <= 1'b0;
      end
      else if (stop_c)
      begin
        state   <= ST_IDLE;
        ack_drv <= 1'b0;
      end
      else if (scl_rise && state != ST_ACK && bit_cnt < 4'h8)
      begin
        shift   <= {shift[6:0], sda_q[1]};
        bit_cnt <= bit_cnt + 4'h1;
      end
      else if (scl_fall && bit_cnt == 4'h8)
      begin
        bit_cnt <= 4'h0;
        case (state)
          ST_ADDR:
          begin
            ack_drv   <= addr_hit;
            state     <= addr_hit ? ST_ACK : ST_IGNORE;
            ret_state <= ST_INDEX;
          end
          ST_INDEX:
          begin
            index     <= shift;
            ack_drv   <= 1'b1;
            state     <= ST_ACK;
            ret_state <= ST_COUNT;
          end
          ST_COUNT:
          begin
            ack_drv   <= 1'b1;
            state     <= ST_ACK;
            ret_state <= ST_DATA;
          end
          ST_DATA:
          begin
            // Full buffer refuses the byte rather than dropping it
            ack_drv   <= fifo_ready;
            push      <= fifo_ready;
            push_word <= '{index: index, data: shift};
            index     <= index + 8'(fifo_ready);
            state     <= ST_ACK;
            ret_state <= ST_DATA;
          end
          default:
            state <= ST_IGNORE;
        endcase
      end
      else if (scl_fall && state == ST_ACK)
      begin
        ack_drv <= 1'b0;
        state   <= ret_state;
      end
    end
  end
  cfb_fifo #(
    .WIDTH ($bits(cfb_wr_t)),
    .DEPTH (FIFO_DEPTH)
  ) cfb_fifo_inst (
    .clock_i     (clock_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (push),
    .in_ready_o  (fifo_ready),
    .in_data_i   (push_word),
    .out_valid_o (pop_valid),
    .out_ready_i (pop_ready),
    .out_data_o  (pop_word)
  );

  // ========================================================
  // Avalon-MM slave, one wait state per access
  logic ack_q;
  wire  acc      = avs_read_i || avs_write_i;
  wire  cfg_hit  = (avs_address_i <= OFS_CFG_LAST) &&
                   (avs_address_i[1:0] == 2'h0);
  wire  sw_wr    = avs_write_i && ack_q && cfg_hit;
  wire  [2:0] sw_idx = avs_address_i[4:2];
  // Software write has priority; bus bytes wait one cycle
  assign pop_ready = !sw_wr;
  wire  [31:0] status_word = {16'h0000, 1'b0, my_addr, 5'h00,
                              ref_running, valid, awake};

  assign avs_waitrequest_o = acc && !ack_q;

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      ack_q          <= 1'b0;
      avs_readdata_o <= 32'h0000_0000;
      cfg[0]         <= RST_BYTE0;
      for (int i = 1; i < NUM_BYTES; i++)
        cfg[i] <= RST_OTHER;
    end
    else
    begin
      ack_q <= acc && !ack_q;
      if (avs_read_i && !ack_q)
        avs_readdata_o <= cfg_hit ? {24'h000000, cfg[sw_idx]} :
                          (avs_address_i == OFS_STATUS) ?
                          status_word : 32'h0000_0000;
      if (sw_wr)
        cfg[sw_idx] <= avs_writedata_i[7:0];
      else if (pop_valid && pop_word.index < 8'(NUM_BYTES))
        cfg[pop_word.index[2:0]] <= pop_word.data;
    end
  end

endmodule : cfb_top

// [sim/cfb_top_props.sv]
`timescale 1ns/1ps
// ==========================================================
// Pin-level checker for the fanout buffer control
module cfb_top_props #(
  parameter int DRIVE_CNT = 50,
  parameter int STAB_CNT  = 100
) (
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  input  wire logic       avs_read_i,
  input  wire logic       avs_write_i,
  input  wire logic       avs_waitrequest_o,
  input  wire logic       scl_i,
  input  wire logic       sda_oe_o,
  input  wire logic       ref_clock_i,
  input  wire logic       powergood_sleep_n_i,
  input  wire logic [5:0] pair_enable_n_i,
  input  wire logic [5:0] diff_clock_output_t_o,
  input  wire logic [5:0] diff_clock_output_c_o
);
  logic [1:0] ref_q;
  logic [7:0] ref_idle;
  logic [7:0] dis0;

  // Saturating counts: cycles since a reference edge, cycles pin 0 is off
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      ref_q    <= 2'h0;
      ref_idle <= 8'h00;
      dis0     <= 8'h00;
    end
    else
    begin
      ref_q    <= {ref_q[0], ref_clock_i};
      ref_idle <= (ref_q == 2'h1) ? 8'h00 : ref_idle + {7'h0, ~&ref_idle};
      dis0     <= pair_enable_n_i[0] ? dis0 + {7'h0, ~&dis0} : 8'h00;
    end
  end

  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  ack_start_a: assert property ($rose(sda_oe_o) |-> !scl_i)
    else $error("ack raised while bus clock high");
  ack_end_a: assert property ($fell(sda_oe_o) |-> !scl_i)
    else $error("ack released while bus clock high");
  ack_hold_a: assert property (
    scl_i && $past(scl_i, 4) |-> $stable(sda_oe_o))
    else $error("data line changed during bus clock high");
  ack_len_a: assert property ($rose(sda_oe_o) |-> sda_oe_o [*8])
    else $error("ack pulse too short");
  ack_ref_a: assert property (ref_idle > 8'h50 |-> !sda_oe_o)
    else $error("ack given with reference clock stopped");
  sleep_low_a: assert property (
    !powergood_sleep_n_i [*6] |->
      (diff_clock_output_t_o | diff_clock_output_c_o) == 6'h00)
    else $error("outputs driven while asleep");
  pair_park_a: assert property (
    dis0 > 8'h30 && ref_idle < 8'h10 |->
      (diff_clock_output_t_o[0] | diff_clock_output_c_o[0]) == 1'b0)
    else $error("disabled pair not parked low");
  read_wait_a: assert property (
    $rose(avs_read_i || avs_write_i) |->
      avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("register access wait not one cycle");
endmodule : cfb_top_props

bind cfb_top cfb_top_props #(
  .DRIVE_CNT(DRIVE_CNT),
  .STAB_CNT (STAB_CNT)
) cfb_top_props_inst (
  .clock_i               (clock_i),
  .rst_n_i               (rst_n_i),
  .avs_read_i            (avs_read_i),
  .avs_write_i           (avs_write_i),
  .avs_waitrequest_o     (avs_waitrequest_o),
  .scl_i                 (scl_i),
  .sda_oe_o              (sda_oe_o),
  .ref_clock_i           (ref_clock_i),
  .powergood_sleep_n_i   (powergood_sleep_n_i),
  .pair_enable_n_i       (pair_enable_n_i),
  .diff_clock_output_t_o (diff_clock_output_t_o),
  .diff_clock_output_c_o (diff_clock_output_c_o)
);

// [sim/cfb_host.sv]
`timescale 1ns/1ps
// ==========================================================
// Bus host model, open drain, quarter bit of Q clocks
module cfb_host #(
  parameter int Q = 80 // 320 clocks a bit, about 390 kHz
) (
  input  wire logic clock_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_oe_o
);
  initial
  begin
    scl_o    = 1'b1;
    sda_oe_o = 1'b0;
  end

  task automatic wait_q();
    repeat (Q) @(posedge clock_i);
  endtask : wait_q

  // Data set while clock low, line sampled mid clock-high
  task automatic send_bit(input logic b, output logic seen);
    sda_oe_o <= ~b;
    wait_q();
    scl_o <= 1'b1;
    wait_q();
    seen = sda_i;
    wait_q();
    scl_o <= 1'b0;
    wait_q();
  endtask : send_bit

  // One byte MSB first, then the released acknowledge slot
  task automatic send_byte(input logic [7:0] b, inout int acks);
    logic s;
    for (int k = 7; k >= 0; k--) send_bit(b[k], s);
    send_bit(1'b1, s);
    acks += int'(!s);
  endtask : send_byte

  task automatic frame(input logic [6:0] addr, input logic [7:0] idx,
                       input logic [7:0] cnt, input logic [7:0] base,
                       output int acks);
    acks = 0;
    sda_oe_o <= 1'b1;
    wait_q();
    scl_o <= 1'b0;
    wait_q();
    send_byte({addr, 1'b0}, acks);
    send_byte(idx, acks);
    send_byte(cnt, acks);
    for (int i = 0; i < cnt; i++) send_byte(base + 8'(i), acks);
    sda_oe_o <= 1'b1;
    wait_q();
    scl_o <= 1'b1;
    wait_q();
    sda_oe_o <= 1'b0;
    wait_q();
  endtask : frame
endmodule : cfb_host

// [sim/test_cfb_top.sv]
`timescale 1ns/1ps
// ==========================================================
// Bench: host model on the bus, register tasks, pin stimulus
module test_cfb_top;
  import cfb_pkg::*;
  localparam int DRV = 50;
  logic        clock_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [5:0]  avs_address_i = 6'h00;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        scl, h_oe, d_oe, d_sda;
  logic        ref_clock_i = 1'b0;
  logic        ref_run = 1'b1;
  logic        pg = 1'b0;
  logic [1:0]  sel = 2'h0;
  logic [5:0]  pins = 6'h3e;
  logic [5:0]  t_o, c_o;
  logic [31:0] q;
  int          acks;
  int          bad_count = 0;
  int          checks_done = 0;
  wire         sda_w = ~h_oe & (~d_oe | d_sda);

  always #4 clock_i = ~clock_i;
  always #40 if (ref_run) ref_clock_i = ~ref_clock_i;

  cfb_top #(.DRIVE_CNT(DRV), .STAB_CNT(100)) cfb_top_inst (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .scl_i(scl), .sda_i(sda_w),
    .sda_o(d_sda), .sda_oe_o(d_oe), .ref_clock_i(ref_clock_i),
    .powergood_sleep_n_i(pg), .bus_addr_select_i(sel),
    .pair_enable_n_i(pins), .diff_clock_output_t_o(t_o),
    .diff_clock_output_c_o(c_o));
  cfb_host cfb_host_inst (.clock_i(clock_i), .sda_i(sda_w), .scl_o(scl),
    .sda_oe_o(h_oe));

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic hold(input int n);
    repeat (n) @(posedge clock_i);
  endtask : hold

  task automatic avs(input logic w, input logic [5:0] a,
                     input logic [31:0] d);
    @(posedge clock_i);
    avs_address_i   <= a;
    avs_write_i     <= w;
    avs_read_i      <= ~w;
    avs_writedata_i <= d;
    do @(posedge clock_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
  endtask : avs

  task automatic do_reset();
    rst_n_i <= 1'b0;
    pg      <= 1'b0;
    hold(4);
    rst_n_i <= 1'b1;
  endtask : do_reset

  // Both lines of a pair must toggle when running, stay low when parked
  task automatic watch(input int k, input logic run);
    int ht, hc;
    ht = 0;
    hc = 0;
    repeat (40)
    begin
      @(posedge clock_i);
      ht += int'(t_o[k]);
      hc += int'(c_o[k]);
    end
    chk({ht > 0, ht < 40, hc > 0, hc < 40}, run ? 4'hf : 4'h5);
  endtask : watch

  task automatic t_addr_sel();
    logic [6:0] adr [3];
    adr = '{ADDR_LOW, ADDR_MID, ADDR_HIGH};
    for (int s = 0; s < 3; s++)
    begin
      do_reset();
      sel <= 2'(s);
      avs(1'b0, OFS_STATUS, 32'h0);
      chk(q[0], 1'b0);
      pg <= 1'b1;
      hold(DRV + 20);
      avs(1'b0, OFS_STATUS, 32'h0);
      chk(q[14:8], adr[s]);
      chk(q[2:0], 3'h7);
    end
    sel <= SEL_LOW;
    avs(1'b0, OFS_STATUS, 32'h0);
    chk(q[14:8], ADDR_HIGH);
  endtask : t_addr_sel

  task automatic t_bus();
    cfb_host_inst.frame(ADDR_HIGH, 8'h01, 8'h03, 8'ha0, acks);
    chk(acks, 6);
    hold(20);
    for (int i = 0; i < 5; i++)
    begin
      avs(1'b0, 6'(4 * i), 32'h0);
      chk(q, (i == 0) ? 32'hff : (i == 4) ? 32'h0 : 32'ha0 + i - 1);
    end
    cfb_host_inst.frame(ADDR_LOW, 8'h01, 8'h02, 8'h55, acks);
    chk(acks, 0);
    avs(1'b0, 6'h04, 32'h0);
    chk(q, 32'ha0);
    ref_run <= 1'b0;
    hold(100);
    avs(1'b0, OFS_STATUS, 32'h0);
    chk(q[2], 1'b0);
    cfb_host_inst.frame(ADDR_HIGH, 8'h02, 8'h01, 8'h77, acks);
    chk(acks, 0);
    ref_run <= 1'b1;
    hold(50);
    avs(1'b0, 6'h08, 32'h0);
    chk(q, 32'ha1);
  endtask : t_bus

  task automatic t_pins();
    watch(0, 1'b1);
    watch(1, 1'b0);
    pins <= 6'h3f;
    hold(33);
    watch(0, 1'b0);
    pins <= 6'h3e;
    hold(33);
    watch(0, 1'b1);
    cfb_host_inst.frame(ADDR_HIGH, 8'h00, 8'h01, 8'hfe, acks);
    chk(acks, 4);
    hold(40);
    watch(0, 1'b0);
    avs(1'b1, 6'h00, 32'hff);
    hold(33);
    watch(0, 1'b1);
    pg <= 1'b0;
    hold(6);
    watch(0, 1'b0);
    avs(1'b0, OFS_STATUS, 32'h0);
    chk(q[1:0], 2'h0);
    pg <= 1'b1;
    hold(DRV + 20);
    watch(0, 1'b1);
  endtask : t_pins

  task automatic t_avs();
    avs(1'b1, 6'h24, 32'h5a);
    avs(1'b0, 6'h24, 32'h0);
    chk(q, 32'h0);
    avs(1'b1, OFS_STATUS, 32'h0);
    avs(1'b0, OFS_STATUS, 32'h0);
    chk(q[2:0], 3'h7);
    avs(1'b1, OFS_CFG_LAST, 32'h1234_5678);
    avs(1'b0, OFS_CFG_LAST, 32'h0);
    chk(q, 32'h78);
  endtask : t_avs

  initial
  begin
    t_addr_sel();
    t_bus();
    t_pins();
    t_avs();
    close_out();
  end

  // Bus traffic dominates: about 60k cycles expected
  initial
  begin
    hold(90000);
    bad_count++;
    close_out();
  end
endmodule : test_cfb_top
